// File: rtl/gpcp_top.sv
/*
 Parallel control port of a four-engine gang programmer: pin inputs for
 script and site selection, active-low start, busy, pass and fail per
 module, a launch interface to the engines and a small register port.
 Assumes the engines report each site's end on the same clock, and that
 the host pins are asynchronous to clk.
*/
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module gpcp_top
    import gpcp_pkg::*;
#(
    parameter int ENGINES = NUM_ENGINES,
    parameter int CHANNELS = CHANNELS_PER_ENGINE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic script_index_bit0,
    input wire logic script_index_bit1,
    input wire logic script_index_bit2,
    input wire logic script_index_bit3,
    input wire logic script_index_bit4,
    input wire logic site_index_bit0,
    input wire logic site_index_bit1,
    input wire logic module1_go_n,
    input wire logic module2_go_n,
    input wire logic module3_go_n,
    input wire logic module4_go_n,
    output logic module1_active_n,
    output logic module1_ok_n,
    output logic module1_bad_n,
    output logic module2_active_n,
    output logic module2_ok_n,
    output logic module2_bad_n,
    output logic module3_active_n,
    output logic module3_ok_n,
    output logic module3_bad_n,
    output logic module4_active_n,
    output logic module4_ok_n,
    output logic module4_bad_n,
    output logic [ENGINES-1:0] eng_launch,
    output logic [ENGINES*SCRIPT_BITS-1:0] eng_script,
    output logic [ENGINES*CHANNELS-1:0] eng_site_mask,
    input wire logic [ENGINES*CHANNELS-1:0] eng_site_done,
    input wire logic [ENGINES*CHANNELS-1:0] eng_site_pass,
    input wire logic [ADDR_BITS-1:0] reg_addr,
    input wire logic [DATA_BITS-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_BITS-1:0] reg_rdata,
    output logic irq
);

    localparam int SITES = ENGINES * CHANNELS;

    logic [PIN_BITS-1:0] pin_raw;
    logic [PIN_BITS-1:0] pin_meta_reg;
    logic [PIN_BITS-1:0] pin_sync_reg;
    logic [ENGINES-1:0] go_prev_reg;
    logic [ENGINES-1:0] go_sync;
    logic [ENGINES-1:0] go_fall;
    logic [SCRIPT_BITS-1:0] script_sync;
    logic [SITE_BITS-1:0] site_sync;
    logic [CHANNELS-1:0] mask_decoded;

    wire logic [ENGINES-1:0] active_n_w;
    wire logic [ENGINES-1:0] ok_n_w;
    wire logic [ENGINES-1:0] bad_n_w;
    wire logic [ENGINES-1:0] done_evt;
    wire logic [ENGINES-1:0] refused_evt;
    wire logic [SITES-1:0] site_pass_w;
    wire logic [SITES-1:0] site_done_w;
    wire logic [ENGINES*SELECT_LANE_BITS-1:0] select_w;

    logic [ENGINES-1:0] control_reg;
    logic [IRQ_BITS-1:0] irq_mask_reg;
    logic [IRQ_BITS-1:0] irq_stat_reg;
    logic [IRQ_BITS-1:0] irq_stat_next;
    logic [IRQ_BITS-1:0] irq_events;
    logic [IRQ_BITS-1:0] irq_clear;
    logic irq_reg;
    logic [DATA_BITS-1:0] rdata_reg;

    // Cumulative decode: index k puts channels 0..k in use
    function automatic logic [CHANNELS-1:0] site_decode(
        input logic [SITE_BITS-1:0] idx
    );
        logic [CHANNELS-1:0] m;
        m = '0;
        for (int c = 0; c < CHANNELS; c++) begin
            m[c] = (c <= int'(idx));
        end
        return m;
    endfunction

    assign pin_raw = {module4_go_n, module3_go_n, module2_go_n,
        module1_go_n, site_index_bit1, site_index_bit0,
        script_index_bit4, script_index_bit3, script_index_bit2,
        script_index_bit1, script_index_bit0};

    // Host pins are asynchronous; two stages before any use
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_reg <= PIN_SYNC_RESET;
            pin_sync_reg <= PIN_SYNC_RESET;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign go_sync = pin_sync_reg[PIN_GO_LSB +: ENGINES];
    assign script_sync = pin_sync_reg[PIN_SCRIPT_LSB +: SCRIPT_BITS];
    assign site_sync = pin_sync_reg[PIN_SITE_LSB +: SITE_BITS];
    assign mask_decoded = site_decode(site_sync);

    // Edge, not level: a start held low does not relaunch
    always_ff @(posedge clk) begin
        if (rst) begin
            go_prev_reg <= '1;
        end else begin
            go_prev_reg <= go_sync;
        end
    end

    assign go_fall = go_prev_reg & ~go_sync;

    // One engine per module, each owning four adjacent sites
    for (genvar e = 0; e < ENGINES; e++) begin : g_engine
        gpcp_state_t state_reg;
        logic launch_reg;
        logic active_n_reg;
        logic ok_n_reg;
        logic bad_n_reg;
        logic [SCRIPT_BITS-1:0] script_reg;
        logic [SITE_BITS-1:0] site_reg;
        logic [CHANNELS-1:0] used_reg;
        logic [CHANNELS-1:0] seen_reg;
        logic [CHANNELS-1:0] pass_reg;
        logic [CHANNELS-1:0] done_in;
        logic [CHANNELS-1:0] pass_in;
        logic [CHANNELS-1:0] seen_now;
        logic [CHANNELS-1:0] pass_now;
        logic start_ok;
        logic finish;
        logic all_pass;

        assign done_in = eng_site_done[e*CHANNELS +: CHANNELS];
        assign pass_in = eng_site_pass[e*CHANNELS +: CHANNELS];
        assign seen_now = seen_reg | (done_in & used_reg);
        assign pass_now = pass_reg | (done_in & pass_in & used_reg);
        assign start_ok = go_fall[e] & control_reg[e]
            & (state_reg != GPCP_RUN);
        // Run ends once every site in use has reported
        assign finish = (state_reg == GPCP_RUN)
            & ((seen_now & used_reg) == used_reg);
        assign all_pass = ((pass_now & used_reg) == used_reg);

        always_ff @(posedge clk) begin
            if (rst) begin
                state_reg <= GPCP_IDLE;
            end else begin
                unique case (state_reg)
                    GPCP_IDLE: begin
                        if (start_ok) begin
                            state_reg <= GPCP_RUN;
                        end
                    end
                    GPCP_RUN: begin
                        if (finish) begin
                            state_reg <= GPCP_DONE;
                        end
                    end
                    GPCP_DONE: begin
                        if (start_ok) begin
                            state_reg <= GPCP_RUN;
                        end
                    end
                    default: begin
                        state_reg <= GPCP_IDLE;
                    end
                endcase
            end
        end

        // Selects captured at start; later pin changes do not matter
        always_ff @(posedge clk) begin
            if (rst) begin
                script_reg <= '0;
                site_reg <= '0;
                used_reg <= '0;
            end else if (start_ok) begin
                script_reg <= script_sync;
                site_reg <= site_sync;
                used_reg <= mask_decoded;
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                seen_reg <= '0;
                pass_reg <= '0;
            end else if (start_ok) begin
                seen_reg <= '0;
                pass_reg <= '0;
            end else if (state_reg == GPCP_RUN) begin
                seen_reg <= seen_now;
                pass_reg <= pass_now;
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                launch_reg <= 1'b0;
            end else begin
                launch_reg <= start_ok;
            end
        end

        // Outputs idle high; exactly one result held after a run
        always_ff @(posedge clk) begin
            if (rst) begin
                active_n_reg <= 1'b1;
                ok_n_reg <= 1'b1;
                bad_n_reg <= 1'b1;
            end else if (start_ok) begin
                active_n_reg <= 1'b0;
                ok_n_reg <= 1'b1;
                bad_n_reg <= 1'b1;
            end else if (finish) begin
                active_n_reg <= 1'b1;
                ok_n_reg <= ~all_pass;
                bad_n_reg <= all_pass;
            end
        end

        assign active_n_w[e] = active_n_reg;
        assign ok_n_w[e] = ok_n_reg;
        assign bad_n_w[e] = bad_n_reg;
        assign eng_launch[e] = launch_reg;
        assign eng_script[e*SCRIPT_BITS +: SCRIPT_BITS] = script_reg;
        assign eng_site_mask[e*CHANNELS +: CHANNELS] = used_reg;
        assign site_pass_w[e*CHANNELS +: CHANNELS] = pass_reg;
        assign site_done_w[e*CHANNELS +: CHANNELS] = seen_reg;
        assign done_evt[e] = finish;
        assign refused_evt[e] = go_fall[e] & ~start_ok;
        assign select_w[e*SELECT_LANE_BITS +: SELECT_LANE_BITS] =
            {{(SELECT_LANE_BITS-SCRIPT_BITS-SITE_BITS){1'b0}},
            site_reg, script_reg};
    end

    assign module1_active_n = active_n_w[0];
    assign module1_ok_n = ok_n_w[0];
    assign module1_bad_n = bad_n_w[0];
    assign module2_active_n = active_n_w[1];
    assign module2_ok_n = ok_n_w[1];
    assign module2_bad_n = bad_n_w[1];
    assign module3_active_n = active_n_w[2];
    assign module3_ok_n = ok_n_w[2];
    assign module3_bad_n = bad_n_w[2];
    assign module4_active_n = active_n_w[3];
    assign module4_ok_n = ok_n_w[3];
    assign module4_bad_n = bad_n_w[3];

    // Software control: per-engine start enable, interrupt mask
    always_ff @(posedge clk) begin
        if (rst) begin
            control_reg <= CONTROL_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CONTROL) begin
                control_reg <= reg_wdata[ENGINES-1:0];
            end
            if (reg_addr == ADDR_IRQ_MASK) begin
                irq_mask_reg <= reg_wdata[IRQ_BITS-1:0];
            end
        end
    end

    // Sticky events; a set in the clearing cycle survives
    always_comb begin
        irq_events = '0;
        irq_events[IRQ_DONE_LSB +: ENGINES] = done_evt;
        irq_events[IRQ_REFUSED_LSB +: ENGINES] = refused_evt;
        irq_clear = '0;
        if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
            irq_clear = reg_wdata[IRQ_BITS-1:0];
        end
        irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_events;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_reg <= |(irq_stat_next & irq_mask_reg);
        end
    end

    assign irq = irq_reg;

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= DATA_ZERO;
        end else if (reg_rd) begin
            rdata_reg <= DATA_ZERO;
            unique case (reg_addr)
                ADDR_STATUS: begin
                    rdata_reg[STAT_ACTIVE_LSB +: ENGINES] <= ~active_n_w;
                    rdata_reg[STAT_OK_LSB +: ENGINES] <= ~ok_n_w;
                    rdata_reg[STAT_BAD_LSB +: ENGINES] <= ~bad_n_w;
                end
                ADDR_IRQ_STAT: begin
                    rdata_reg[IRQ_BITS-1:0] <= irq_stat_reg;
                end
                ADDR_IRQ_MASK: begin
                    rdata_reg[IRQ_BITS-1:0] <= irq_mask_reg;
                end
                // Per-site detail lives here, never on the pins
                ADDR_SITE_RESULT: begin
                    rdata_reg[RESULT_PASS_LSB +: SITES] <= site_pass_w;
                    rdata_reg[RESULT_DONE_LSB +: SITES] <= site_done_w;
                end
                ADDR_CONTROL: begin
                    rdata_reg[ENGINES-1:0] <= control_reg;
                end
                ADDR_SELECT: begin
                    rdata_reg[ENGINES*SELECT_LANE_BITS-1:0] <= select_w;
                end
                default: begin
                    rdata_reg <= DATA_ZERO;
                end
            endcase
        end else begin
            rdata_reg <= DATA_ZERO;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule

// File: shared/gpcp_pkg.sv
/*
 Constants, register map and state type of the gang programmer control
 port. Assumes a single clock domain and a word-wide register port.
*/
package gpcp_pkg;

    localparam int NUM_ENGINES = 4;
    localparam int CHANNELS_PER_ENGINE = 4;
    localparam int NUM_SITES = NUM_ENGINES * CHANNELS_PER_ENGINE;
    localparam int SCRIPT_BITS = 5;
    localparam int SITE_BITS = 2;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 32;
    localparam int PIN_BITS = SCRIPT_BITS + SITE_BITS + NUM_ENGINES;
    localparam int IRQ_BITS = 2 * NUM_ENGINES;

    // Pin bundle layout: script, site, then the four start lines
    localparam int PIN_SCRIPT_LSB = 0;
    localparam int PIN_SITE_LSB = 5;
    localparam int PIN_GO_LSB = 7;
    // Start lines idle high, selects idle low
    localparam logic [10:0] PIN_SYNC_RESET = 11'h780;

    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_SITE_RESULT = 8'h0c;
    localparam logic [7:0] ADDR_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_SELECT = 8'h14;

    localparam int STAT_ACTIVE_LSB = 0;
    localparam int STAT_OK_LSB = 4;
    localparam int STAT_BAD_LSB = 8;
    localparam int IRQ_DONE_LSB = 0;
    localparam int IRQ_REFUSED_LSB = 4;
    localparam int RESULT_PASS_LSB = 0;
    localparam int RESULT_DONE_LSB = 16;
    localparam int SELECT_LANE_BITS = 8;

    localparam logic [3:0] CONTROL_RESET = 4'hf;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        GPCP_IDLE,
        GPCP_RUN,
        GPCP_DONE
    } gpcp_state_t;

endpackage

// File: dv/gpcp_monitor.sv
/*
 Checker for the control port: start, result and read timing of
 module 1. Assumes it is bound to gpcp_top and sees only its ports.
*/
module gpcp_monitor
    import gpcp_pkg::*;
#(
    parameter int ENGINES = NUM_ENGINES,
    parameter int CHANNELS = CHANNELS_PER_ENGINE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic site_index_bit0,
    input wire logic site_index_bit1,
    input wire logic module1_go_n,
    input wire logic module1_active_n,
    input wire logic module1_ok_n,
    input wire logic module1_bad_n,
    input wire logic [ENGINES-1:0] eng_launch,
    input wire logic [ENGINES*CHANNELS-1:0] eng_site_mask,
    input wire logic [ENGINES*CHANNELS-1:0] eng_site_done,
    input wire logic [ENGINES*CHANNELS-1:0] eng_site_pass,
    input wire logic reg_rd,
    input wire logic [DATA_BITS-1:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic fail_seen_reg;
    logic [4:0] span;
    assign span = (5'h01 << ({site_index_bit1, site_index_bit0} + 1)) - 5'h01;
    // Any used site of engine 1 failed in this run
    always_ff @(posedge clk) begin
        if (rst || eng_launch[0]) begin
            fail_seen_reg <= 1'b0;
        end else if (|(eng_site_done[3:0] & ~eng_site_pass[3:0]
                       & eng_site_mask[3:0])) begin
            fail_seen_reg <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_one_result: assert property (!(!module1_ok_n && !module1_bad_n))
        else $error("pass and fail both asserted");
    chk_busy_no_result: assert property (
        !module1_active_n |-> module1_ok_n && module1_bad_n)
        else $error("result shown while busy");
    chk_launch_pulse: assert property (eng_launch[0] |=> !eng_launch[0])
        else $error("launch longer than one cycle");
    chk_launch_busy: assert property ($rose(eng_launch[0]) |->
        !module1_active_n && $past(module1_active_n))
        else $error("busy not entered at launch");
    chk_start_cause: assert property (
        eng_launch[0] |-> !$past(module1_go_n, 2))
        else $error("launch without start low");
    chk_site_decode: assert property (
        eng_launch[0] |-> eng_site_mask[3:0] == span[3:0])
        else $error("channel mask wrong");
    chk_fail_any: assert property ($rose(module1_active_n) |->
        module1_bad_n == !fail_seen_reg && module1_ok_n == fail_seen_reg)
        else $error("result does not match sites");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == DATA_ZERO)
        else $error("read data outside read slot");
    cov_launch: cover property (eng_launch[0]);
    cov_pass: cover property ($fell(module1_ok_n));
    cov_fail: cover property ($fell(module1_bad_n));
endmodule

bind gpcp_top gpcp_monitor #(.ENGINES(ENGINES), .CHANNELS(CHANNELS)) u_mon (
    .clk, .rst, .site_index_bit0, .site_index_bit1, .module1_go_n,
    .module1_active_n, .module1_ok_n, .module1_bad_n, .eng_launch,
    .eng_site_mask, .eng_site_done, .eng_site_pass, .reg_rd, .reg_rdata
);

// File: dv/gpcp_engine_model.sv
/*
 Behavioural model of the four programming engines behind the port.
 Assumes launch is a one-cycle pulse and the mask is valid with it.
*/
module gpcp_engine_model
    import gpcp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] launch,
    input wire logic [15:0] mask,
    input wire logic [15:0] fail_pat,
    input wire logic [3:0] dly,
    output logic [15:0] done,
    output logic [15:0] pass
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_reg [4];
    logic [15:0] mask_reg;
    logic tog_reg;
    always_ff @(posedge clk) begin
        done <= '0;
        // Toggles outside reports so stale values are never trusted
        pass <= {16{tog_reg}};
        if (rst) begin
            tog_reg <= 1'b0;
        end else begin
            tog_reg <= ~tog_reg;
        end
        for (int e = 0; e < 4; e++) begin
            if (rst) begin
                cnt_reg[e] <= 4'h0;
            end else if (launch[e]) begin
                cnt_reg[e] <= dly + 4'h1;
                mask_reg[4*e+:4] <= mask[4*e+:4];
            end else if (cnt_reg[e] == 4'h1) begin
                // Per-site outcome
                done[4*e+:4] <= mask_reg[4*e+:4];
                pass[4*e+:4] <= ~fail_pat[4*e+:4];
                cnt_reg[e] <= 4'h0;
            end else if (cnt_reg[e] != 4'h0) begin
                cnt_reg[e] <= cnt_reg[e] - 4'h1;
            end
        end
    end
endmodule

// File: dv/gang_programmer_control_port_bench.sv
/*
 Self-checking bench for gpcp_top with the engine model.
 Assumes one 20 MHz clock and a synchronous active-high reset.
*/
module gang_programmer_control_port_bench
    import gpcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, wr = 0, rd = 0, irq;
    logic [4:0] scr = '0;
    logic [1:0] site = '0;
    logic [3:0] go_n = 4'hf, dly = '0, launch, act_n, ok_n, bad_n;
    logic [19:0] escr;
    logic [15:0] emask, edone, epass, fail_pat = '0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0, rdata, d;
    int failures = 0, samples_checked = 0;
    always #25 clk = ~clk;
    gpcp_top uut (.clk, .rst,
        .script_index_bit0(scr[0]), .script_index_bit1(scr[1]),
        .script_index_bit2(scr[2]), .script_index_bit3(scr[3]),
        .script_index_bit4(scr[4]),
        .site_index_bit0(site[0]), .site_index_bit1(site[1]),
        .module1_go_n(go_n[0]), .module2_go_n(go_n[1]),
        .module3_go_n(go_n[2]), .module4_go_n(go_n[3]),
        .module1_active_n(act_n[0]), .module1_ok_n(ok_n[0]),
        .module1_bad_n(bad_n[0]), .module2_active_n(act_n[1]),
        .module2_ok_n(ok_n[1]), .module2_bad_n(bad_n[1]),
        .module3_active_n(act_n[2]), .module3_ok_n(ok_n[2]),
        .module3_bad_n(bad_n[2]), .module4_active_n(act_n[3]),
        .module4_ok_n(ok_n[3]), .module4_bad_n(bad_n[3]),
        .eng_launch(launch), .eng_script(escr), .eng_site_mask(emask),
        .eng_site_done(edone), .eng_site_pass(epass), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .irq);
    gpcp_engine_model model (.clk, .rst, .launch, .mask(emask), .fail_pat,
        .dly, .done(edone), .pass(epass));
    task automatic results();
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) begin
            addr <= a;
            wdata <= v;
            wr <= 1'b1;
        end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk) begin
            addr <= a;
            rd <= 1'b1;
        end
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic logic [3:0] mask_of(input logic [1:0] s);
        logic [4:0] t;
        t = (5'h01 << (s + 1)) - 5'h01;
        return t[3:0];
    endfunction
    // Start one engine; optionally a second start while it runs
    task automatic run(input int e, input bit twice);
        logic [3:0] m;
        logic bad;
        int n;
        // Selects were set by a non-blocking write; read them an edge on
        @(posedge clk) go_n[e] <= 1'b0;
        m = mask_of(site);
        bad = |(m & fail_pat[4*e+:4]);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (launch[e] !== 1'b1 && n < 10);
        chk(escr[5*e+:5], scr);
        chk(emask[4*e+:4], m);
        chk(act_n[e], 1'b0);
        @(posedge clk) go_n[e] <= 1'b1;
        if (twice) begin
            @(posedge clk) go_n[e] <= 1'b0;
            @(posedge clk) go_n[e] <= 1'b1;
        end
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (act_n[e] !== 1'b1 && n < 20);
        chk(bad_n[e], !bad);
        chk(ok_n[e], bad);
        rreg(ADDR_STATUS);
        chk(d[STAT_OK_LSB+e], !bad);
        rreg(ADDR_SELECT);
        chk(d[8*e+:8], {1'b0, site, scr});
    endtask
    initial begin
        void'($urandom(86));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rreg(ADDR_CONTROL);
        chk(d, {28'h0, CONTROL_RESET});
        rreg(ADDR_IRQ_MASK);
        chk(d, {24'h0, IRQ_MASK_RESET});
        rreg(8'h20);
        chk(d, DATA_ZERO);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) begin
                scr <= (i == 0) ? 5'h1f : 5'($urandom);
                site <= 2'($urandom);
                dly <= 4'($urandom % 8);
                fail_pat <= (i % 3 == 0) ? 16'($urandom) : 16'h0000;
            end
            run(i % 4, 1'b0);
        end
        // Failures only on unused channels, then only on the last one
        @(posedge clk) begin
            site <= 2'h0;
            fail_pat <= 16'hfffe;
        end
        run(0, 1'b0);
        @(posedge clk) begin
            site <= 2'h3;
            fail_pat <= 16'h0080;
        end
        run(1, 1'b0);
        // Per-site detail: channels 0-2 passed, channel 3 failed
        rreg(ADDR_SITE_RESULT);
        chk(d[7:4], 4'h7);
        chk(d[23:20], 4'hf);
        // Done interrupt and a start refused while busy
        wreg(ADDR_IRQ_STAT, 32'h0000_00ff);
        wreg(ADDR_IRQ_MASK, 32'h0000_0001);
        @(posedge clk) begin
            dly <= 4'h7;
            fail_pat <= 16'h0000;
        end
        run(0, 1'b1);
        chk(irq, 1'b1);
        rreg(ADDR_IRQ_STAT);
        chk(d[7:0], 8'h11);
        wreg(ADDR_IRQ_STAT, 32'h0000_0011);
        @(posedge clk);
        #1 chk(irq, 1'b0);
        // Disabled engine ignores its start line
        wreg(ADDR_CONTROL, 32'h0000_000e);
        @(posedge clk) go_n[0] <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk(act_n[0], 1'b1);
        rreg(ADDR_IRQ_STAT);
        chk(d[7:0], 8'h10);
        @(posedge clk) go_n[0] <= 1'b1;
        results();
    end
    initial begin
        #1000000;
        failures++;
        results();
    end
endmodule
